/* File: design/usmh_map.vh */
`ifndef USMH_MAP_VH
`define USMH_MAP_VH
// Register indices; the APB byte address is four times the index
`define USMH_IDX_DATA 3'h0
`define USMH_IDX_IEN 3'h1
`define USMH_IDX_FIFO 3'h2
`define USMH_IDX_LCTL 3'h3
`define USMH_IDX_MCTL 3'h4
`define USMH_IDX_LSTAT 3'h5
`define USMH_IDX_MSTAT 3'h6
`define USMH_IDX_SCR 3'h7
// Line control fields
`define USMH_LC_DLAB 7
`define USMH_LC_BREAK 6
`define USMH_LC_STICK 5
`define USMH_LC_EVEN 4
`define USMH_LC_PEN 3
`define USMH_LC_STOP 2
// Modem control fields
`define USMH_MC_LOOP 4
`define USMH_MC_IRQEN 3
`define USMH_MC_RTS 1
`define USMH_MC_DTR 0
// Fifo control fields
`define USMH_FC_TXRST 2
`define USMH_FC_RXRST 1
`define USMH_FC_EN 0
// Interrupt enable fields
`define USMH_IE_MS 3
`define USMH_IE_LS 2
`define USMH_IE_TX 1
`define USMH_IE_RX 0
// Interrupt identification codes
`define USMH_ID_NONE 4'h1
`define USMH_ID_LS 4'h6
`define USMH_ID_RX 4'h4
`define USMH_ID_TO 4'hC
`define USMH_ID_TX 4'h2
`define USMH_ID_MS 4'h0
// Receive trigger levels
`define USMH_LVL_0 5'h01
`define USMH_LVL_1 5'h04
`define USMH_LVL_2 5'h08
`define USMH_LVL_3 5'h0E
// Reset values
`define USMH_RST_DIV 16'h0001
`define USMH_RST_LCTL 8'h00
`define USMH_RST_MCTL 5'h00
`define USMH_RST_IEN 4'h0
`define USMH_RST_SCR 8'h00
// Timing in 16x baud ticks; fifo depth in entries
`define USMH_TK_BIT 6'h0F
`define USMH_TK_HALF 6'h07
`define USMH_TK_STOP1 6'h0F
`define USMH_TK_STOP15 6'h17
`define USMH_TK_STOP2 6'h1F
`define USMH_TK_TIMEOUT 10'h280
`define USMH_DEPTH 5'h10
`endif

/* File: design/usmh_uart.v */
// Summary of operation
// - Characters go out and come in least significant bit first.
// - Without fifo mode, fifo error, fifo-enabled and timeout bits read zero.
// - Fifo mode: status bit 7 set while any queued byte has an error.
// - Status bit 6 high only when holding stage and shifter are empty.
// - Non-fifo: bit 5 set on move to shifter; interrupts if enabled.
// - Fifo mode: holding-empty set when fifo empties, cleared by a write.
// - Break flag when input stays spacing for a whole character.
// - Framing flag on missing stop bit, parity flag on wrong parity.
// - Fifo mode: error flags describe the byte at the fifo head.
// - Overrun when a byte arrives with no room: non-fifo overwrites unread data, fifo mode drops the byte; status read clears flags.
// - Status bit 0 high while received data wait unread.
// - Loopback: output forced high, input isolated, modem outputs inactive.
// - Loopback feeds modem inputs from control bits 0 to 3.
// - Control bit 3 gates the interrupt output; bit 2 unused outside loopback.
// - RTS and DTR pins carry inverted control bits 1 and 0.
// - Modem status bits 7..4 show inverted inputs, or control bits in loopback.
// - Change flags for carrier, set-ready and clear-to-send since last read.
// - Ring flag only on ring pin rising from low to high.
// - Divisor access bit maps offsets 0 and 1 to the baud divisor.
// - Trigger field picks 1, 4, 8 or 14 bytes for the receive interrupt.
// - Modem change interrupt only when enable bit 3 is set.
`timescale 1ns/10ps
`include "usmh_map.vh"
module usmh_uart (
  input wire REF_CLK,
  input wire RESETN,
  input wire CLK_EN,
  input wire PSEL,
  input wire PENABLE,
  input wire PWRITE,
  input wire [4:0] PADDR,
  input wire [31:0] PWDATA,
  output reg [31:0] PRDATA,
  output reg PREADY,
  output reg PSLVERR,
  input wire SERIAL_INPUT_LINE,
  input wire CTS_N,
  input wire DSR_N,
  input wire RI_N,
  input wire DCD_N,
  output reg SERIAL_OUTPUT_LINE,
  output reg RTS_N,
  output reg DTR_N,
  output reg IRQ
);
  localparam TX_IDLE = 2'b00;
  localparam TX_DATA = 2'b01;
  localparam TX_STOP = 2'b10;
  localparam RX_IDLE = 2'b00;
  localparam RX_START = 2'b01;
  localparam RX_DATA = 2'b10;
  localparam RX_STOP = 2'b11;

  reg [7:0] lctl;
  reg [4:0] mctl;
  reg [3:0] ien;
  reg [15:0] div;
  reg [7:0] scr;
  reg fifo_en;
  reg [1:0] thr_sel;
  reg [15:0] bcnt;
  reg tick;
  reg [7:0] tx_mem [0:15];
  reg [3:0] tx_wp, tx_rp;
  reg [4:0] tx_cnt;
  reg thre, tx_ip;
  reg [1:0] tx_st;
  reg [5:0] tx_tk;
  reg [3:0] tx_left;
  reg [8:0] tx_sh;
  reg tx_bit;
  reg [10:0] rx_mem [0:15];
  reg [3:0] rx_wp, rx_rp;
  reg [4:0] rx_cnt;
  reg [1:0] rx_st;
  reg [5:0] rx_tk;
  reg [3:0] rx_left;
  reg [8:0] rx_sh;
  reg rx_prev, hfresh;
  reg ls_oe, ls_pe, ls_fe, ls_bi, rfe;
  reg [9:0] to_cnt;
  reg [3:0] ms_prev, ms_dlt;
  reg [7:0] rd_byte;
  reg [3:0] int_id;
  reg [4:0] thr_lvl;
  reg any_err;
  reg [3:0] off;
  integer i;

  // Parity bit for the current line setup
  function par_of;
    input [7:0] d;
    input [7:0] lc;
    begin
      if (lc[`USMH_LC_STICK])
        par_of = ~lc[`USMH_LC_EVEN];
      else
        par_of = lc[`USMH_LC_EVEN] ? ^d : ~^d;
    end
  endfunction

  // Bus decode; access completes on the edge that sees PREADY high
  wire setup = PSEL & ~PENABLE;
  wire done = PSEL & PENABLE & PREADY;
  wire [2:0] idx = PADDR[4:2];
  wire bad = |PADDR[1:0];
  wire wr = done & PWRITE & ~bad;
  wire rd = done & ~PWRITE & ~bad;
  wire dlab = lctl[`USMH_LC_DLAB];
  wire loop = mctl[`USMH_MC_LOOP];
  wire pen = lctl[`USMH_LC_PEN];
  wire wr_thr = wr & (idx == `USMH_IDX_DATA) & ~dlab;
  wire rd_rbr = rd & (idx == `USMH_IDX_DATA) & ~dlab;
  wire wr_fcr = wr & (idx == `USMH_IDX_FIFO);
  wire rd_isr = rd & (idx == `USMH_IDX_FIFO);
  wire rd_lsr = rd & (idx == `USMH_IDX_LSTAT);
  wire rd_msr = rd & (idx == `USMH_IDX_MSTAT);
  wire fen_chg = PWDATA[`USMH_FC_EN] ^ fifo_en;
  wire rx_rst = wr_fcr & (PWDATA[`USMH_FC_RXRST] | fen_chg);
  wire tx_rst = wr_fcr & (PWDATA[`USMH_FC_TXRST] | fen_chg);

  // Character shape
  wire [3:0] dlen = 4'h5 + {2'h0, lctl[1:0]};
  wire [3:0] nbits = dlen + {3'h0, pen};
  wire [7:0] dmask = 8'hFF >> (2'h3 - lctl[1:0]);
  wire stop_long = lctl[`USMH_LC_STOP];
  wire [5:0] stop_tk = ~stop_long ? `USMH_TK_STOP1 :
    (lctl[1:0] == 2'h0) ? `USMH_TK_STOP15 : `USMH_TK_STOP2;

  // APB answer: ready in the access cycle, read data taken at setup
  always @(posedge REF_CLK or negedge RESETN) begin
    if (!RESETN) begin
      PREADY <= 1'b0;
      PSLVERR <= 1'b0;
      PRDATA <= 32'h00000000;
    end else if (CLK_EN) begin
      if (setup) begin
        PREADY <= 1'b1;
        PSLVERR <= bad;
        PRDATA <= {24'h000000, bad ? 8'h00 : rd_byte};
      end else if (done) begin
        PREADY <= 1'b0;
        PSLVERR <= 1'b0;
      end
    end
  end

  // Software-written configuration
  always @(posedge REF_CLK or negedge RESETN) begin
    if (!RESETN) begin
      lctl <= `USMH_RST_LCTL;
      mctl <= `USMH_RST_MCTL;
      ien <= `USMH_RST_IEN;
      div <= `USMH_RST_DIV;
      scr <= `USMH_RST_SCR;
      fifo_en <= 1'b0;
      thr_sel <= 2'h0;
    end else if (CLK_EN && wr) begin
      case (idx)
        `USMH_IDX_DATA: if (dlab) div[7:0] <= PWDATA[7:0];
        `USMH_IDX_IEN: begin
          if (dlab)
            div[15:8] <= PWDATA[7:0];
          else
            ien <= PWDATA[3:0];
        end
        `USMH_IDX_FIFO: begin
          fifo_en <= PWDATA[`USMH_FC_EN];
          thr_sel <= PWDATA[7:6];
        end
        `USMH_IDX_LCTL: lctl <= PWDATA[7:0];
        `USMH_IDX_MCTL: mctl <= PWDATA[4:0];
        `USMH_IDX_SCR: scr <= PWDATA[7:0];
        default: ;
      endcase
    end
  end

  // 16x baud tick; a zero divisor behaves like one
  wire [15:0] div_top = (div == 16'h0000) ? 16'h0000 : div - 16'h0001;
  always @(posedge REF_CLK or negedge RESETN) begin
    if (!RESETN) begin
      bcnt <= 16'h0000;
      tick <= 1'b0;
    end else if (CLK_EN) begin
      if (bcnt >= div_top) begin
        bcnt <= 16'h0000;
        tick <= 1'b1;
      end else begin
        bcnt <= bcnt + 16'h0001;
        tick <= 1'b0;
      end
    end
  end

  // Transmit queue; depth one outside fifo mode
  wire tx_full = fifo_en ? (tx_cnt == `USMH_DEPTH) : (tx_cnt != 5'h00);
  wire tx_push = wr_thr & ~tx_full;
  wire tx_pop = (tx_st == TX_IDLE) & (tx_cnt != 5'h00);
  wire thre_set = tx_rst | (tx_pop & (tx_cnt == 5'h01) & ~tx_push);
  wire next_thre = thre_set | (thre & ~tx_push);
  wire ien_tx_on = wr & (idx == `USMH_IDX_IEN) & ~dlab & PWDATA[`USMH_IE_TX];
  wire tx_ip_clr = rd_isr & (PRDATA[3:0] == `USMH_ID_TX);
  wire [7:0] tx_d = tx_mem[tx_rp] & dmask;

  always @(posedge REF_CLK) begin
    if (CLK_EN && tx_push)
      tx_mem[tx_wp] <= PWDATA[7:0];
  end

  always @(posedge REF_CLK or negedge RESETN) begin
    if (!RESETN) begin
      tx_wp <= 4'h0;
      tx_rp <= 4'h0;
      tx_cnt <= 5'h00;
      thre <= 1'b1;
      tx_ip <= 1'b0;
    end else if (CLK_EN) begin
      if (tx_rst) begin
        tx_wp <= 4'h0;
        tx_rp <= 4'h0;
        tx_cnt <= 5'h00;
      end else begin
        if (tx_push)
          tx_wp <= tx_wp + 4'h1;
        if (tx_pop)
          tx_rp <= tx_rp + 4'h1;
        tx_cnt <= tx_cnt + {4'h0, tx_push} - {4'h0, tx_pop};
      end
      thre <= next_thre;
      // Pending until a data write or an identification read that shows it
      tx_ip <= next_thre & (thre_set | ien_tx_on | (tx_ip & ~tx_ip_clr));
    end
  end

  // Transmit shifter: start bit, data, optional parity, stop time
  always @(posedge REF_CLK or negedge RESETN) begin
    if (!RESETN) begin
      tx_st <= TX_IDLE;
      tx_tk <= 6'h00;
      tx_left <= 4'h0;
      tx_sh <= 9'h000;
      tx_bit <= 1'b1;
    end else if (CLK_EN) begin
      case (tx_st)
        TX_IDLE: begin
          tx_bit <= 1'b1;
          if (tx_pop) begin
            tx_sh <= {1'b0, tx_d} | ({8'h00, pen & par_of(tx_d, lctl)} << dlen);
            tx_left <= nbits;
            tx_tk <= `USMH_TK_BIT;
            tx_bit <= 1'b0;
            tx_st <= TX_DATA;
          end
        end
        TX_DATA: if (tick) begin
          if (tx_tk != 6'h00)
            tx_tk <= tx_tk - 6'h01;
          else if (tx_left == 4'h0) begin
            tx_bit <= 1'b1;
            tx_tk <= stop_tk;
            tx_st <= TX_STOP;
          end else begin
            tx_bit <= tx_sh[0];
            tx_sh <= tx_sh >> 1;
            tx_left <= tx_left - 4'h1;
            tx_tk <= `USMH_TK_BIT;
          end
        end
        TX_STOP: if (tick) begin
          if (tx_tk != 6'h00)
            tx_tk <= tx_tk - 6'h01;
          else
            tx_st <= TX_IDLE;
        end
        default: tx_st <= TX_IDLE;
      endcase
    end
  end

  // Receive input; loopback takes the internal transmit bit instead
  wire rx_in = loop ? tx_bit : SERIAL_INPUT_LINE;
  wire [8:0] rx_fr = rx_sh >> (4'h9 - nbits);
  wire [7:0] rx_d = rx_fr[7:0] & dmask;
  wire rx_bi = ~rx_in & (rx_fr == 9'h000);
  wire rx_fe = ~rx_in;
  wire rx_pe = pen & (rx_fr[dlen] != par_of(rx_d, lctl));
  wire rx_done = (rx_st == RX_STOP) & tick & (rx_tk == 6'h00);

  // Receive sampler: mid-bit samples, shifted in from the top
  always @(posedge REF_CLK or negedge RESETN) begin
    if (!RESETN) begin
      rx_st <= RX_IDLE;
      rx_tk <= 6'h00;
      rx_left <= 4'h0;
      rx_sh <= 9'h000;
      rx_prev <= 1'b1;
    end else if (CLK_EN) begin
      rx_prev <= rx_in;
      case (rx_st)
        // Edge start, so a held break cannot restart a character
        RX_IDLE: if (rx_prev && !rx_in) begin
          rx_tk <= `USMH_TK_HALF;
          rx_st <= RX_START;
        end
        RX_START: if (tick) begin
          if (rx_tk != 6'h00)
            rx_tk <= rx_tk - 6'h01;
          else if (!rx_in) begin
            rx_tk <= `USMH_TK_BIT;
            rx_left <= nbits;
            rx_st <= RX_DATA;
          end else
            rx_st <= RX_IDLE;
        end
        RX_DATA: if (tick) begin
          if (rx_tk != 6'h00)
            rx_tk <= rx_tk - 6'h01;
          else begin
            rx_sh <= {rx_in, rx_sh[8:1]};
            rx_left <= rx_left - 4'h1;
            rx_tk <= `USMH_TK_BIT;
            if (rx_left == 4'h1)
              rx_st <= RX_STOP;
          end
        end
        RX_STOP: if (tick) begin
          if (rx_tk != 6'h00)
            rx_tk <= rx_tk - 6'h01;
          else
            rx_st <= RX_IDLE;
        end
        default: rx_st <= RX_IDLE;
      endcase
    end
  end

  // Receive queue: each entry holds break, framing, parity and data
  wire rx_full = fifo_en ? (rx_cnt == `USMH_DEPTH) : (rx_cnt != 5'h00);
  wire rx_pop = rd_rbr & (rx_cnt != 5'h00);
  wire rx_ovw = rx_done & rx_full & ~rx_pop;
  wire rx_push = rx_done & (~rx_full | rx_pop);
  wire [10:0] head = rx_mem[rx_rp];

  always @(posedge REF_CLK) begin
    if (CLK_EN) begin
      if (rx_push)
        rx_mem[rx_wp] <= {rx_bi, rx_fe, rx_pe, rx_d};
      else if (rx_ovw && !fifo_en)
        rx_mem[rx_rp] <= {rx_bi, rx_fe, rx_pe, rx_d};
    end
  end

  always @(posedge REF_CLK or negedge RESETN) begin
    if (!RESETN) begin
      rx_wp <= 4'h0;
      rx_rp <= 4'h0;
      rx_cnt <= 5'h00;
      hfresh <= 1'b0;
    end else if (CLK_EN) begin
      if (rx_rst) begin
        rx_wp <= 4'h0;
        rx_rp <= 4'h0;
        rx_cnt <= 5'h00;
        hfresh <= 1'b0;
      end else begin
        if (rx_push)
          rx_wp <= rx_wp + 4'h1;
        if (rx_pop)
          rx_rp <= rx_rp + 4'h1;
        rx_cnt <= rx_cnt + {4'h0, rx_push} - {4'h0, rx_pop};
        // A new byte reached the head of the queue
        hfresh <= (rx_pop & ((rx_cnt != 5'h01) | rx_push)) |
          (rx_push & (rx_cnt == 5'h00)) | (rx_ovw & ~fifo_en);
      end
    end
  end

  // Any queued byte with an error
  always @* begin
    any_err = 1'b0;
    off = 4'h0;
    for (i = 0; i < 16; i = i + 1) begin
      off = i[3:0] - rx_rp;
      if (({1'b0, off} < rx_cnt) && (|rx_mem[i][10:8]))
        any_err = 1'b1;
    end
  end

  // Sticky line flags; only bits seen by the status read are cleared
  wire [7:0] ls_clr = rd_lsr ? PRDATA[7:0] : 8'h00;
  wire hd_set = hfresh & (rx_cnt != 5'h00);
  always @(posedge REF_CLK or negedge RESETN) begin
    if (!RESETN) begin
      ls_oe <= 1'b0;
      ls_pe <= 1'b0;
      ls_fe <= 1'b0;
      ls_bi <= 1'b0;
      rfe <= 1'b0;
    end else if (CLK_EN) begin
      ls_oe <= rx_ovw | (ls_oe & ~ls_clr[1]);
      ls_pe <= (hd_set & head[8]) | (ls_pe & ~ls_clr[2]);
      ls_fe <= (hd_set & head[9]) | (ls_fe & ~ls_clr[3]);
      ls_bi <= (hd_set & head[10]) | (ls_bi & ~ls_clr[4]);
      rfe <= fifo_en & (any_err | (rfe & ~ls_clr[7]));
    end
  end

  // Character timeout: data left idle for about four characters
  always @(posedge REF_CLK or negedge RESETN) begin
    if (!RESETN)
      to_cnt <= 10'h000;
    else if (CLK_EN) begin
      if (rx_cnt == 5'h00 || rx_push || rx_pop)
        to_cnt <= 10'h000;
      else if (tick && to_cnt != `USMH_TK_TIMEOUT)
        to_cnt <= to_cnt + 10'h001;
    end
  end
  wire to_hit = fifo_en & (to_cnt == `USMH_TK_TIMEOUT) & (rx_cnt != 5'h00);

  // Modem inputs as active-high levels: DCD, RI, DSR, CTS
  wire [3:0] ms_now = loop ? {mctl[3], mctl[2], mctl[0], mctl[1]} :
    ~{DCD_N, RI_N, DSR_N, CTS_N};
  wire [3:0] ms_evt = {ms_now[3] ^ ms_prev[3],
    ms_prev[2] & ~ms_now[2],
    ms_now[1] ^ ms_prev[1],
    ms_now[0] ^ ms_prev[0]};
  wire [3:0] ms_clr = rd_msr ? PRDATA[3:0] : 4'h0;
  always @(posedge REF_CLK or negedge RESETN) begin
    if (!RESETN) begin
      ms_prev <= 4'h0;
      ms_dlt <= 4'h0;
    end else if (CLK_EN) begin
      ms_prev <= ms_now;
      ms_dlt <= ms_evt | (ms_dlt & ~ms_clr);
    end
  end

  // Receive trigger level
  always @* begin
    case (thr_sel)
      2'h0: thr_lvl = `USMH_LVL_0;
      2'h1: thr_lvl = `USMH_LVL_1;
      2'h2: thr_lvl = `USMH_LVL_2;
      default: thr_lvl = `USMH_LVL_3;
    endcase
  end

  // Interrupt priority: line, data, timeout, transmit, modem
  wire ls_any = ls_oe | ls_pe | ls_fe | ls_bi;
  wire rx_lvl = fifo_en ? (rx_cnt >= thr_lvl) : (rx_cnt != 5'h00);
  always @* begin
    if (ien[`USMH_IE_LS] && ls_any)
      int_id = `USMH_ID_LS;
    else if (ien[`USMH_IE_RX] && rx_lvl)
      int_id = `USMH_ID_RX;
    else if (ien[`USMH_IE_RX] && to_hit)
      int_id = `USMH_ID_TO;
    else if (ien[`USMH_IE_TX] && tx_ip)
      int_id = `USMH_ID_TX;
    else if (ien[`USMH_IE_MS] && (|ms_dlt))
      int_id = `USMH_ID_MS;
    else
      int_id = `USMH_ID_NONE;
  end

  // Register read view
  wire temt = thre & (tx_st == TX_IDLE);
  wire [7:0] lsr = {rfe, temt, thre, ls_bi, ls_fe, ls_pe, ls_oe,
    rx_cnt != 5'h00};
  always @* begin
    case (idx)
      `USMH_IDX_DATA: rd_byte = dlab ? div[7:0] : head[7:0];
      `USMH_IDX_IEN: rd_byte = dlab ? div[15:8] : {4'h0, ien};
      `USMH_IDX_FIFO: rd_byte = {fifo_en, fifo_en, 2'h0, int_id};
      `USMH_IDX_LCTL: rd_byte = lctl;
      `USMH_IDX_MCTL: rd_byte = {3'h0, mctl};
      `USMH_IDX_LSTAT: rd_byte = lsr;
      `USMH_IDX_MSTAT: rd_byte = {ms_now, ms_dlt};
      `USMH_IDX_SCR: rd_byte = scr;
      default: rd_byte = 8'h00;
    endcase
  end

  // Pins; registered so each output comes from a flop
  always @(posedge REF_CLK or negedge RESETN) begin
    if (!RESETN) begin
      SERIAL_OUTPUT_LINE <= 1'b1;
      RTS_N <= 1'b1;
      DTR_N <= 1'b1;
      IRQ <= 1'b0;
    end else if (CLK_EN) begin
      SERIAL_OUTPUT_LINE <= loop | (~lctl[`USMH_LC_BREAK] & tx_bit);
      RTS_N <= loop | ~mctl[`USMH_MC_RTS];
      DTR_N <= loop | ~mctl[`USMH_MC_DTR];
      IRQ <= mctl[`USMH_MC_IRQEN] & (int_id != `USMH_ID_NONE);
    end
  end
endmodule // usmh_uart

/* File: verif/uart_status_modem_handshake_test.sv */
`timescale 1ns/10ps
module uart_status_modem_handshake_test;
  logic clk, rst_n, psel, penable, pwrite, last_err;
  logic [4:0] paddr;
  logic [31:0] pwdata, rdata;
  logic [7:0] rnd;
  logic [3:0] o, p;
  wire [31:0] prdata;
  wire [3:0] mp;
  wire pready, pslverr, serial_input_line, serial_output_line, rts_n, dtr_n, irq;
  int miscompares = 0;
  int compares = 0;
  int cyc = 0;
  int n0;
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  usmh_uart uut (.REF_CLK(clk), .RESETN(rst_n), .CLK_EN(1'b1), .PSEL(psel),
    .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
    .PREADY(pready), .PSLVERR(pslverr), .SERIAL_INPUT_LINE(serial_input_line), .CTS_N(mp[0]),
    .DSR_N(mp[1]), .RI_N(mp[2]), .DCD_N(mp[3]), .SERIAL_OUTPUT_LINE(serial_output_line),
    .RTS_N(rts_n), .DTR_N(dtr_n), .IRQ(irq));
  usmh_peer peer (.clk(clk), .rx_line(serial_output_line), .tx_line(serial_input_line), .pins(mp));
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  // Live levels inverted; deltas from old to new pin levels
  function automatic logic [7:0] msr_exp(input logic [3:0] a, input logic [3:0] b);
    return {~b, a[3] ^ b[3], ~a[2] & b[2], a[1:0] ^ b[1:0]};
  endfunction
  task automatic chkv(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Request held until ready is seen high at a rising edge
  task automatic apb(input logic w, input logic [4:0] ad, input logic [7:0] d);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= ad;
    pwdata <= {24'h000000, d};
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    rdata = prdata;
    last_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [4:0] ad, input logic [7:0] d);
    apb(1'b1, ad, d);
  endtask
  task automatic rdc(input string nm, input logic [4:0] ad, input logic [7:0] e,
    input logic [7:0] m);
    apb(1'b0, ad, 8'h00);
    chkv(nm, {24'h000000, e & m}, rdata & {24'hFFFFFF, m});
  endtask
  task automatic rxcase(input logic [8:0] d, input int nb, input logic st, input logic [7:0] e);
    wr(5'h0C, nb == 9 ? 8'h1B : 8'h03);
    peer.send_char(d, nb, st);
    rdc("line status", 5'h14, e, 8'hFF);
    rdc("rx data", 5'h00, d[7:0], 8'hFF);
    rdc("line status", 5'h14, 8'h60, 8'hFF);
  endtask
  task automatic tend(input string nm);
    $display("test %s done", nm);
  endtask
  task automatic complete_run;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // Hang guard, far above the few thousand cycles the run needs
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      miscompares++;
      complete_run();
    end
  end
  initial begin
    rst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 5'h00;
    pwdata = 32'h00000000;
    rnd = 8'h4B;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    rdc("line status", 5'h14, 8'h60, 8'hFF);
    rdc("modem status", 5'h18, 8'h00, 8'hFF);
    rdc("int id", 5'h08, 8'h01, 8'hFF);
    rdc("misaligned", 5'h15, 8'h00, 8'hFF);
    chkv("slave error", 32'h00000001, {31'h00000000, last_err});
    tend("reset");
    repeat (4) begin
      rnd = lfsr(rnd);
      wr(5'h1C, rnd);
      rdc("scratch", 5'h1C, rnd, 8'hFF);
    end
    wr(5'h0C, 8'h83);
    wr(5'h00, 8'h01);
    wr(5'h04, rnd);
    rdc("divisor high", 5'h04, rnd, 8'hFF);
    wr(5'h04, 8'h00);
    wr(5'h0C, 8'h03);
    wr(5'h04, 8'h05);
    rdc("int enable", 5'h04, 8'h05, 8'hFF);
    wr(5'h0C, 8'h83);
    rdc("divisor high", 5'h04, 8'h00, 8'hFF);
    rdc("divisor low", 5'h00, 8'h01, 8'hFF);
    wr(5'h0C, 8'h03);
    wr(5'h04, 8'h00);
    tend("map");
    rnd = lfsr(rnd);
    n0 = peer.got_n;
    wr(5'h00, rnd);
    rdc("tx busy status", 5'h14, 8'h20, 8'h60);
    repeat (400) if (peer.got_n == n0) @(posedge clk);
    chkv("tx byte", {24'h000000, rnd}, {24'h000000, peer.got_byte});
    repeat (40) @(posedge clk);
    rdc("tx idle status", 5'h14, 8'h60, 8'hFF);
    tend("transmit");
    rxcase({1'b0, rnd}, 8, 1'b1, 8'h61);
    rxcase(9'h000, 8, 1'b0, 8'h79);
    rxcase({1'b0, rnd}, 8, 1'b0, 8'h69);
    rxcase({~^rnd, rnd}, 9, 1'b1, 8'h65);
    wr(5'h0C, 8'h03);
    rnd = lfsr(rnd);
    peer.send_char(9'h0A5, 8, 1'b1);
    peer.send_char({1'b0, rnd}, 8, 1'b1);
    rdc("line status", 5'h14, 8'h63, 8'hFF);
    rdc("rx data", 5'h00, rnd, 8'hFF);
    rdc("line status", 5'h14, 8'h60, 8'hFF);
    tend("receive");
    wr(5'h08, 8'h07);
    rdc("fifo id", 5'h08, 8'hC0, 8'hC0);
    wr(5'h0C, 8'h1B);
    peer.send_char(9'h13C, 9, 1'b1);
    peer.send_char({^rnd, rnd}, 9, 1'b1);
    rdc("line status", 5'h14, 8'hE5, 8'hFF);
    rdc("line status", 5'h14, 8'hE1, 8'hFF);
    rdc("rx data", 5'h00, 8'h3C, 8'hFF);
    rdc("line status", 5'h14, 8'hE1, 8'hFF);
    rdc("rx data", 5'h00, rnd, 8'hFF);
    rdc("line status", 5'h14, 8'h60, 8'hFF);
    wr(5'h00, rnd);
    wr(5'h00, rnd);
    rdc("tx fifo status", 5'h14, 8'h00, 8'h60);
    wr(5'h08, 8'h00);
    wr(5'h0C, 8'h03);
    rdc("int id", 5'h08, 8'h00, 8'hC8);
    tend("fifo");
    wr(5'h10, 8'h03);
    repeat (3) @(posedge clk);
    chkv("rts pin", 32'h00000000, {31'h00000000, rts_n});
    chkv("dtr pin", 32'h00000000, {31'h00000000, dtr_n});
    o = 4'hF;
    repeat (8) begin
      rnd = lfsr(rnd);
      p = rnd[3:0];
      peer.set_pins(p);
      repeat (3) @(posedge clk);
      rdc("modem status", 5'h18, msr_exp(o, p), 8'hFF);
      o = p;
    end
    wr(5'h10, 8'h15);
    repeat (3) @(posedge clk);
    chkv("rts pin", 32'h00000001, {31'h00000000, rts_n});
    chkv("dtr pin", 32'h00000001, {31'h00000000, dtr_n});
    chkv("serial out", 32'h00000001, {31'h00000000, serial_output_line});
    peer.set_pins(~o);
    repeat (3) @(posedge clk);
    rdc("loop status", 5'h18, 8'h60, 8'hF0);
    tend("modem");
    wr(5'h10, 8'h08);
    wr(5'h04, 8'h08);
    rdc("modem status", 5'h18, msr_exp(4'h9, ~o), 8'hFF);
    peer.set_pins(mp ^ 4'h1);
    repeat (4) @(posedge clk);
    chkv("irq", 32'h00000001, {31'h00000000, irq});
    rdc("modem status", 5'h18, 8'h01, 8'h0F);
    repeat (4) @(posedge clk);
    chkv("irq", 32'h00000000, {31'h00000000, irq});
    wr(5'h04, 8'h00);
    peer.set_pins(mp ^ 4'h1);
    repeat (4) @(posedge clk);
    chkv("irq", 32'h00000000, {31'h00000000, irq});
    wr(5'h10, 8'h00);
    wr(5'h04, 8'h08);
    repeat (4) @(posedge clk);
    chkv("irq", 32'h00000000, {31'h00000000, irq});
    wr(5'h10, 8'h08);
    repeat (4) @(posedge clk);
    chkv("irq", 32'h00000001, {31'h00000000, irq});
    tend("interrupt");
    complete_run();
  end
endmodule // uart_status_modem_handshake_test

/* File: verif/usmh_peer.sv */
`timescale 1ns/10ps
module usmh_peer (
  input wire logic clk,
  input wire logic rx_line,
  output logic tx_line,
  output logic [3:0] pins
);
  logic [7:0] got_byte;
  int got_n = 0;
  // Line idles marking, modem pins inactive
  initial begin
    tx_line = 1'b1;
    pins = 4'hF;
  end
  task automatic set_pins(input logic [3:0] p);
    @(posedge clk) pins <= p;
  endtask
  // Sixteen clocks a bit at divisor one; stop level chosen to force faults
  task automatic send_char(input logic [8:0] d, input int nb, input logic st);
    int i;
    @(posedge clk) tx_line <= 1'b0;
    repeat (16) @(posedge clk);
    for (i = 0; i < nb; i++) begin
      tx_line <= d[i];
      repeat (16) @(posedge clk);
    end
    tx_line <= st;
    repeat (16) @(posedge clk);
    tx_line <= 1'b1;
    repeat (16) @(posedge clk);
  endtask
  // Receiver samples mid-bit; a glitch shorter than half a bit is ignored
  initial forever begin
    @(negedge rx_line);
    repeat (8) @(posedge clk);
    if (rx_line === 1'b0) begin
      for (int k = 0; k < 8; k++) begin
        repeat (16) @(posedge clk);
        got_byte[k] = rx_line;
      end
      got_n++;
    end
  end
endmodule // usmh_peer

/* File: verif/usmh_props.sv */
`timescale 1ns/10ps
module usmh_props (
  input wire logic REF_CLK,
  input wire logic RESETN,
  input wire logic CLK_EN,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [4:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [31:0] PRDATA,
  input wire logic PREADY,
  input wire logic PSLVERR,
  input wire logic SERIAL_INPUT_LINE,
  input wire logic CTS_N,
  input wire logic DSR_N,
  input wire logic RI_N,
  input wire logic DCD_N,
  input wire logic SERIAL_OUTPUT_LINE,
  input wire logic RTS_N,
  input wire logic DTR_N,
  input wire logic IRQ
);
  logic [4:0] mc;
  logic fen;
  logic [3:0] pin_d;
  logic [3:0] pin_dd;
  wire [3:0] pins = {DCD_N, RI_N, DSR_N, CTS_N};
  wire [3:0] lb = {mc[3], mc[2], mc[0], mc[1]};
  wire wdone = PSEL && PENABLE && PREADY && PWRITE && CLK_EN;
  wire setup_rd = PSEL && !PENABLE && !PWRITE && CLK_EN;
  // Shadow of written control state; pins delayed to know they settled
  always_ff @(posedge REF_CLK or negedge RESETN) begin
    if (!RESETN) begin
      mc <= 5'h00;
      fen <= 1'b0;
      pin_d <= 4'hF;
      pin_dd <= 4'hF;
    end else begin
      if (wdone && PADDR == 5'h10) mc <= PWDATA[4:0];
      if (wdone && PADDR == 5'h08) fen <= PWDATA[0];
      pin_d <= pins;
      pin_dd <= pin_d;
    end
  end
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!RESETN);
  AST_RTS: assert property (mc == $past(mc, 2) |-> RTS_N == (mc[4] | ~mc[1]))
    else $error("RTS level wrong");
  AST_DTR: assert property (mc == $past(mc, 2) |-> DTR_N == (mc[4] | ~mc[0]))
    else $error("DTR level wrong");
  AST_LOOP_SERIAL_OUTPUT_LINE: assert property (mc[4] && mc == $past(mc, 2) |-> SERIAL_OUTPUT_LINE)
    else $error("serial output not high in loopback");
  AST_IRQ_GATE: assert property (!mc[3] && mc == $past(mc, 2) |-> !IRQ)
    else $error("interrupt not gated");
  AST_MS_LIVE: assert property (setup_rd && PADDR == 5'h18 && !mc[4] &&
    mc == $past(mc, 2) && pins == pin_d && pin_d == pin_dd |=> PRDATA[7:4] == ~$past(pins))
    else $error("modem status does not follow pins");
  AST_MS_LOOP: assert property (setup_rd && PADDR == 5'h18 && mc[4] &&
    mc == $past(mc, 2) |=> PRDATA[7:4] == lb)
    else $error("loopback modem status wrong");
  AST_NOFIFO: assert property (setup_rd && !fen && (PADDR == 5'h14 || PADDR == 5'h08)
    |=> !PRDATA[7] && (PADDR == 5'h14 || PRDATA[6:3] == 4'h0))
    else $error("fifo-only bit set without fifo mode");
  AST_PREADY: assert property (PSEL && !PENABLE && CLK_EN |=> PREADY ##1 !PREADY)
    else $error("ready not a single access cycle");
  AST_ERR: assert property (PSEL && !PENABLE && PADDR[1:0] != 2'h0 |=> PSLVERR && PRDATA == 0)
    else $error("misaligned access not refused");
  cover property (setup_rd && PADDR == 5'h18 && mc[4]);
  cover property (IRQ && mc[3]);
  cover property (setup_rd && PADDR == 5'h14 && fen);
endmodule // usmh_props
bind usmh_uart usmh_props u_props (.REF_CLK, .RESETN, .CLK_EN, .PSEL, .PENABLE, .PWRITE,
  .PADDR, .PWDATA, .PRDATA, .PREADY, .PSLVERR, .SERIAL_INPUT_LINE, .CTS_N, .DSR_N, .RI_N,
  .DCD_N, .SERIAL_OUTPUT_LINE, .RTS_N, .DTR_N, .IRQ);
